// File: flash_row_pkg.sv
package flash_row_pkg;

   // Row geometry
   localparam int NUM_LATCHES = 32;
   localparam int WORD_W = 14;
   localparam int ROW_W = 10;
   localparam int IDX_W = 5;
   localparam logic [4:0] LAST_IDX = 5'h1f;
   localparam logic [13:0] BLANK_WORD = 14'h3fff;

   // Register offsets on the register port
   localparam logic [2:0] OFS_DATA_LOW = 3'h0;
   localparam logic [2:0] OFS_DATA_HIGH = 3'h1;
   localparam logic [2:0] OFS_ADDR_LOW = 3'h2;
   localparam logic [2:0] OFS_ADDR_HIGH = 3'h3;
   localparam logic [2:0] OFS_CONTROL_ONE = 3'h4;
   localparam logic [2:0] OFS_UNLOCK_KEY = 3'h5;
   localparam logic [2:0] OFS_IRQ_STATUS = 3'h6;
   localparam logic [2:0] OFS_IRQ_MASK = 3'h7;

   // Control one field positions
   localparam int BIT_REGION_SELECT = 6;
   localparam int BIT_LATCH_LOAD_ONLY = 5;
   localparam int BIT_ROW_ERASE = 4;
   localparam int BIT_WRITE_ERROR = 3;
   localparam int BIT_WRITE_ENABLE = 2;
   localparam int BIT_WRITE_START = 1;

   // Interrupt status field positions
   localparam int BIT_IRQ_DONE = 0;
   localparam int BIT_IRQ_ERROR = 1;

   // Unlock key values
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [6:0] RST_ADDR_HIGH = 7'h00;
   localparam logic [5:0] RST_DATA_HIGH = 6'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic [9:0] RST_ROW = 10'h000;

   // Unlock tracker states
   typedef enum logic [1:0] {
      U_IDLE = 2'b00,
      U_GOT_FIRST = 2'b01,
      U_ARMED = 2'b10
   } unlock_t;

   // Sequencer states
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_PROG = 2'b01,
      S_ERASE = 2'b10,
      S_DONE = 2'b11
   } seq_t;

endpackage

// File: flash_row_latch_writer.sv
// How it works
// - A row write only programs, it never erases first, so target words must be blank.
// - One row write always programs all 32 write latches of the row, loaded or still blank.
// - Address bits 14..5 pick the row and address bits 4..0 pick the latch that is loaded.
// - The row is captured at start so no word of one operation leaves that row.
// - After a row write every latch returns to the blank all-ones 14-bit value.
// - After a row erase the latches also return to blank, and unloaded latches stay blank.
// - With the load-only bit set and the erase bit clear, a finished unlock copies the data pair into one latch only.
// - With the load-only and erase bits clear, a finished unlock loads the last latch and programs the row.
// - Nothing starts without a complete unlock, and a broken unlock starts nothing.
// - Erase works on a whole row only, the latch index bits are ignored.
// - A row operation on a protected row clears the start bit and sets the error flag.
`timescale 1ns/1ps
`default_nettype none

module flash_row_latch_writer
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic flash_req,
   output logic flash_erase,
   output logic [9:0] flash_row,
   output logic [4:0] flash_word,
   output logic [13:0] flash_wdata,
   input wire logic flash_ack,
   input wire logic [9:0] protect_rows_below,
   output logic cpu_hold,
   output logic irq
);

   // Register address match, shared by write and read decoding
   function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
      hit = (a == ofs);
   endfunction

   // Row number of a 15-bit flash address
   function automatic logic [9:0] row_of(input logic [6:0] hi,
                                         input logic [7:0] lo);
      row_of = {hi, lo[7:5]};
   endfunction

   logic [7:0] data_low_q;
   logic [5:0] data_high_q;
   logic [7:0] addr_low_q;
   logic [6:0] addr_high_q;
   logic region_q;
   logic load_only_q;
   logic erase_q;
   logic err_q;
   logic err_d;
   logic write_enable_bit_q;
   logic wr_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_stat_d;
   logic [1:0] irq_mask_q;
   logic [7:0] rdata_q;
   logic [13:0] latch_q [0:flash_row_pkg::NUM_LATCHES-1];
   flash_row_pkg::unlock_t unlock_q;
   flash_row_pkg::seq_t seq_q;
   logic [4:0] idx_q;
   logic [9:0] row_q;
   logic is_load_q;
   logic req_q;
   logic erase_req_q;
   logic [4:0] word_q;
   logic [13:0] wdata_q;
   logic hold_q;
   logic irq_q;

   logic wr_key;
   logic wr_ctl;
   logic start_req;
   logic armed_start;
   logic unlock_broken;
   logic [9:0] cur_row;
   logic protected_row;
   logic go_load;
   logic go_row;
   logic go_erase;
   logic deny_prot;
   logic latch_we;
   logic latch_clr;
   logic op_done;
   logic [13:0] data_word;

   // Write decode for the key and control registers
   assign wr_key = reg_wr && hit(reg_addr, flash_row_pkg::OFS_UNLOCK_KEY);
   assign wr_ctl = reg_wr && hit(reg_addr, flash_row_pkg::OFS_CONTROL_ONE);
   assign data_word = {data_high_q, data_low_q};

   // A start request only counts while idle and not already running
   assign start_req = wr_ctl && reg_wdata[flash_row_pkg::BIT_WRITE_START]
                      && (seq_q == flash_row_pkg::S_IDLE) && !wr_q;
   assign armed_start = start_req && (unlock_q == flash_row_pkg::U_ARMED);
   // Any other write inside the key sequence breaks it
   assign unlock_broken = reg_wr && !armed_start
                          && ((unlock_q == flash_row_pkg::U_GOT_FIRST
                               && !(wr_key && reg_wdata
                                    == flash_row_pkg::KEY_SECOND))
                              || unlock_q == flash_row_pkg::U_ARMED);

   assign cur_row = row_of(addr_high_q, addr_low_q);
   assign protected_row = (cur_row < protect_rows_below);

   // Region select high targets areas this block does not serve, so nothing
   // starts there; write enable low also blocks every start.
   // load only
   assign go_load = armed_start && write_enable_bit_q && !region_q && load_only_q
                    && !erase_q;
   assign go_row = armed_start && write_enable_bit_q && !region_q && !load_only_q
                   && !erase_q && !protected_row;
   assign go_erase = armed_start && write_enable_bit_q && !region_q && erase_q
                     && !protected_row;
   assign deny_prot = armed_start && write_enable_bit_q && !region_q
                      && (erase_q || !load_only_q) && protected_row;

   // final latch loaded in the start cycle
   assign latch_we = go_load || go_row;
   // blank after write, blank after erase
   assign latch_clr = (seq_q == flash_row_pkg::S_DONE) && !is_load_q;
   assign op_done = (seq_q == flash_row_pkg::S_DONE);

   // Data and address register pairs
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         data_low_q <= flash_row_pkg::RST_BYTE;
         data_high_q <= flash_row_pkg::RST_DATA_HIGH;
         addr_low_q <= flash_row_pkg::RST_BYTE;
         addr_high_q <= flash_row_pkg::RST_ADDR_HIGH;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, flash_row_pkg::OFS_DATA_LOW))
            data_low_q <= reg_wdata;
         if (hit(reg_addr, flash_row_pkg::OFS_DATA_HIGH))
            data_high_q <= reg_wdata[5:0];
         if (hit(reg_addr, flash_row_pkg::OFS_ADDR_LOW))
            addr_low_q <= reg_wdata;
         if (hit(reg_addr, flash_row_pkg::OFS_ADDR_HIGH))
            addr_high_q <= reg_wdata[6:0];
      end
   end

   // Mode bits; the erase bit is cleared by hardware once the erase is over
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         region_q <= 1'b0;
         load_only_q <= 1'b0;
         erase_q <= 1'b0;
         write_enable_bit_q <= 1'b0;
      end
      else
      begin
         if (wr_ctl)
         begin
            region_q <= reg_wdata[flash_row_pkg::BIT_REGION_SELECT];
            load_only_q <= reg_wdata[flash_row_pkg::BIT_LATCH_LOAD_ONLY];
            write_enable_bit_q <= reg_wdata[flash_row_pkg::BIT_WRITE_ENABLE];
         end
         if (op_done && erase_req_q)
            erase_q <= 1'b0;
         else if (wr_ctl)
            erase_q <= reg_wdata[flash_row_pkg::BIT_ROW_ERASE];
      end
   end

   // Error flag: software may set or clear it, a hardware set wins
   always_comb
   begin
      err_d = wr_ctl ? reg_wdata[flash_row_pkg::BIT_WRITE_ERROR] : err_q;
      if (unlock_broken || deny_prot || (start_req && !armed_start))
         err_d = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         err_q <= 1'b0;
      else
         err_q <= err_d;
   end

   // Start bit can only be set by software, and only through a full unlock
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         wr_q <= 1'b0;
      else if (op_done)
         wr_q <= 1'b0;
      else if (go_load || go_row || go_erase)
         wr_q <= 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         unlock_q <= flash_row_pkg::U_IDLE;
      else
      begin
         case (unlock_q)
            flash_row_pkg::U_IDLE:
               if (wr_key && reg_wdata == flash_row_pkg::KEY_FIRST)
                  unlock_q <= flash_row_pkg::U_GOT_FIRST;
            flash_row_pkg::U_GOT_FIRST:
               if (wr_key && reg_wdata == flash_row_pkg::KEY_SECOND)
                  unlock_q <= flash_row_pkg::U_ARMED;
               else if (reg_wr)
                  unlock_q <= flash_row_pkg::U_IDLE;
            flash_row_pkg::U_ARMED:
               // One shot: any write, used or not, disarms
               if (reg_wr)
                  unlock_q <= flash_row_pkg::U_IDLE;
            default:
               unlock_q <= flash_row_pkg::U_IDLE;
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < flash_row_pkg::NUM_LATCHES; gi = gi + 1)
      begin : g_latch
         always_ff @(posedge clk_sys)
         begin
            if (!resetn || latch_clr)
               latch_q[gi] <= flash_row_pkg::BLANK_WORD;
            else if (latch_we && addr_low_q[4:0] == 5'(gi))
               latch_q[gi] <= data_word;
         end
      end
   endgenerate

   // Row sequencer; the flash macro answers each request with one ack
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         seq_q <= flash_row_pkg::S_IDLE;
         idx_q <= 5'h00;
         row_q <= flash_row_pkg::RST_ROW;
         is_load_q <= 1'b0;
         req_q <= 1'b0;
         erase_req_q <= 1'b0;
         word_q <= 5'h00;
         wdata_q <= flash_row_pkg::BLANK_WORD;
      end
      else
      begin
         case (seq_q)
            flash_row_pkg::S_IDLE:
            begin
               // row frozen for the whole operation
               row_q <= cur_row;
               idx_q <= 5'h00;
               if (go_load)
               begin
                  is_load_q <= 1'b1;
                  erase_req_q <= 1'b0;
                  seq_q <= flash_row_pkg::S_DONE;
               end
               else if (go_row)
               begin
                  is_load_q <= 1'b0;
                  erase_req_q <= 1'b0;
                  seq_q <= flash_row_pkg::S_PROG;
               end
               else if (go_erase)
               begin
                  is_load_q <= 1'b0;
                  erase_req_q <= 1'b1;
                  seq_q <= flash_row_pkg::S_ERASE;
               end
            end
            flash_row_pkg::S_PROG:
            begin
               // program only, no erase request is issued here
               if (!req_q)
               begin
                  req_q <= 1'b1;
                  word_q <= idx_q;
                  wdata_q <= latch_q[idx_q];
               end
               else if (flash_ack)
               begin
                  req_q <= 1'b0;
                  if (idx_q == flash_row_pkg::LAST_IDX)
                     seq_q <= flash_row_pkg::S_DONE;
                  else
                     idx_q <= idx_q + 5'h01;
               end
            end
            flash_row_pkg::S_ERASE:
            begin
               // whole row, word index forced to zero
               if (!req_q)
               begin
                  req_q <= 1'b1;
                  word_q <= 5'h00;
                  wdata_q <= flash_row_pkg::BLANK_WORD;
               end
               else if (flash_ack)
               begin
                  req_q <= 1'b0;
                  seq_q <= flash_row_pkg::S_DONE;
               end
            end
            flash_row_pkg::S_DONE:
               seq_q <= flash_row_pkg::S_IDLE;
            default:
               seq_q <= flash_row_pkg::S_IDLE;
         endcase
      end
   end

   // CPU is held while the array is busy, a latch load never holds it
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         hold_q <= 1'b0;
      else
         hold_q <= go_row || go_erase
                   || seq_q == flash_row_pkg::S_PROG
                   || seq_q == flash_row_pkg::S_ERASE;
   end

   // Sticky events; a read clears them but a same-cycle event survives
   always_comb
   begin
      irq_stat_d = irq_stat_q;
      if (reg_rd && hit(reg_addr, flash_row_pkg::OFS_IRQ_STATUS))
         irq_stat_d = flash_row_pkg::RST_IRQ;
      if (op_done)
         irq_stat_d[flash_row_pkg::BIT_IRQ_DONE] = 1'b1;
      if (err_d && !err_q)
         irq_stat_d[flash_row_pkg::BIT_IRQ_ERROR] = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         irq_stat_q <= flash_row_pkg::RST_IRQ;
         irq_mask_q <= flash_row_pkg::RST_IRQ;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         if (reg_wr && hit(reg_addr, flash_row_pkg::OFS_IRQ_MASK))
            irq_mask_q <= reg_wdata[1:0];
         irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   // Read data, one cycle after the strobe; address high bit 7 reads as one
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         rdata_q <= flash_row_pkg::RST_BYTE;
      else if (reg_rd)
      begin
         case (reg_addr)
            flash_row_pkg::OFS_DATA_LOW:
               rdata_q <= data_low_q;
            flash_row_pkg::OFS_DATA_HIGH:
               rdata_q <= {2'b00, data_high_q};
            flash_row_pkg::OFS_ADDR_LOW:
               rdata_q <= addr_low_q;
            flash_row_pkg::OFS_ADDR_HIGH:
               rdata_q <= {1'b1, addr_high_q};
            flash_row_pkg::OFS_CONTROL_ONE:
               rdata_q <= {1'b0, region_q, load_only_q, erase_q, err_q,
                           write_enable_bit_q, wr_q, 1'b0};
            flash_row_pkg::OFS_IRQ_STATUS:
               rdata_q <= {6'h00, irq_stat_q};
            flash_row_pkg::OFS_IRQ_MASK:
               rdata_q <= {6'h00, irq_mask_q};
            default:
               rdata_q <= flash_row_pkg::RST_BYTE;
         endcase
      end
      else
         rdata_q <= flash_row_pkg::RST_BYTE;
   end

   assign reg_rdata = rdata_q;
   assign flash_req = req_q;
   assign flash_erase = erase_req_q;
   assign flash_row = row_q;
   assign flash_word = word_q;
   assign flash_wdata = wdata_q;
   assign cpu_hold = hold_q;
   assign irq = irq_q;

endmodule

`default_nettype wire

// File: flash_row_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module flash_row_monitor
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic flash_req,
   input wire logic flash_erase,
   input wire logic [9:0] flash_row,
   input wire logic [4:0] flash_word,
   input wire logic [13:0] flash_wdata,
   input wire logic flash_ack,
   input wire logic [9:0] protect_rows_below,
   input wire logic cpu_hold
);
   // All checks share the one clock, so defaults are declared once
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   chk_req_held: assert property (flash_req && !flash_ack |=> flash_req
      && $stable({flash_erase, flash_row, flash_word, flash_wdata}))
      else $error("flash request changed before its ack");
   chk_erase_row: assert property (flash_req && flash_erase
      |-> flash_word == 5'h00) else $error("erase carried a word index");
   chk_word_step: assert property (flash_req && flash_ack && !flash_erase
      && flash_word != 5'h1f |=> !flash_req ##1 (flash_req
      && flash_word == $past(flash_word, 2) + 5'h01))
      else $error("program word did not step by one");
   chk_row_fixed: assert property (flash_req && flash_ack && !flash_erase
      && flash_word != 5'h1f |=> ##1 flash_row == $past(flash_row, 2))
      else $error("program crossed into another row");
   chk_first_word: assert property ($rose(cpu_hold)
      |=> flash_req && flash_word == 5'h00)
      else $error("row operation did not open at word zero");
   chk_protect_row: assert property (flash_req
      |-> flash_row >= protect_rows_below)
      else $error("request issued on a protected row");
   chk_hold_busy: assert property (flash_req |-> cpu_hold)
      else $error("flash request without core hold");
   chk_last_word: assert property (flash_req && flash_ack && !flash_erase
      && flash_word == 5'h1f |=> !flash_req [*3])
      else $error("request issued after the last word");
   cover property (flash_req && flash_ack && flash_erase);
endmodule

`default_nettype wire

// File: flash_row_latch_writer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module flash_row_latch_writer_tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic flash_req;
   logic flash_erase;
   logic [9:0] flash_row;
   logic [4:0] flash_word;
   logic [13:0] flash_wdata;
   logic flash_ack = 1'b0;
   logic [9:0] protect_rows_below = 10'h010;
   logic cpu_hold;
   logic irq;
   logic [29:0] ops[$];
   logic [13:0] lat[32];
   logic [7:0] v;
   logic [9:0] r;
   int ks[3] = '{3, 0, 31};
   int seed = 32'hb583;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;

   flash_row_latch_writer u_flash_row_latch_writer (.clk_sys, .resetn,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_req,
      .flash_erase, .flash_row, .flash_word, .flash_wdata, .flash_ack,
      .protect_rows_below, .cpu_hold, .irq);

   // Clock of 25 ns
   always #12.5 clk_sys = ~clk_sys;

   // Flash stand-in: random stalls so the sequencer must wait for acks
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (flash_req && flash_ack)
         ops.push_back({flash_erase, flash_row, flash_word, flash_wdata});
      flash_ack <= resetn && flash_req && !flash_ack
         && ($random(seed) % 3 == 0);
      if (cycles == 30000)
      begin
         num_errors++;
         final_report();
      end
   end

   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_op(input logic [29:0] got, input logic [29:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t op got %h exp %h", $time, got, exp);
      end
   endtask

   // Expected flash word from the rules: erase flag, row, word index, data
   function automatic logic [29:0] exp_op(input logic ers,
      input logic [9:0] row, input logic [4:0] w, input logic [13:0] d);
      exp_op = {ers, row, w, d};
   endfunction

   // One-cycle strobes with an idle cycle after, so no signal is set twice
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [2:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk_sys);
   endtask

   task automatic unlock(input logic [7:0] ctrl);
      wr(flash_row_pkg::OFS_UNLOCK_KEY, flash_row_pkg::KEY_FIRST);
      wr(flash_row_pkg::OFS_UNLOCK_KEY, flash_row_pkg::KEY_SECOND);
      wr(flash_row_pkg::OFS_CONTROL_ONE, ctrl | 8'h02);
   endtask

   // Polls the start bit; reads never break an unlock
   task automatic wait_idle();
      for (int i = 0; i < 200; i++)
      begin
         rd(3'h4);
         if (v[1] === 1'b0)
            break;
      end
      // A poll limit that runs out is a hang, so it counts as a mismatch
      cmp_reg(v & 8'h02, 8'h00);
   endtask

   task automatic load(input logic [9:0] row, input logic [4:0] idx,
      input logic [7:0] ctrl, input logic upd);
      logic [13:0] d;
      d = 14'($random(seed));
      if (upd)
         lat[idx] = d;
      wr(3'h2, {row[2:0], idx});
      wr(3'h3, {1'b0, row[9:3]});
      wr(3'h0, d[7:0]);
      wr(3'h1, {2'b00, d[13:8]});
      wr(3'h4, ctrl);
      unlock(ctrl);
      wait_idle();
   endtask

   task automatic prog(input logic [9:0] row, input int k);
      for (int i = 0; i <= k; i++)
         load(row, 5'(i), (i == k) ? 8'h04 : 8'h24, 1'b1);
      cmp_reg(8'(ops.size()), 8'h20);
      for (int w = 0; w < 32 && ops.size() > 0; w++)
         cmp_op(ops.pop_front(), exp_op(1'b0, row, 5'(w), lat[w]));
      for (int i = 0; i < 32; i++)
         lat[i] = 14'h3fff;
   endtask

   initial
   begin
      for (int i = 0; i < 32; i++)
         lat[i] = 14'h3fff;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rd(3'h4);
      cmp_reg(v, 8'h00);
      rd(3'h3);
      cmp_reg(v, 8'h80);
      wr(3'h7, 8'h03);
      for (int i = 0; i < 3; i++)
      begin
         r = 10'($random(seed)) | 10'h010;
         prog(r, ks[i]);
         cmp_reg({7'h00, irq}, 8'h01);
         rd(3'h6);
         cmp_reg(v, 8'h01);
         @(posedge clk_sys);
         #1 cmp_reg({7'h00, irq}, 8'h00);
      end
      // Erase after loads leaves latches blank
      for (int i = 0; i < 3; i++)
         load(r, 5'(i), 8'h24, 1'b0);
      load(r, 5'($random(seed)), 8'h14, 1'b0);
      cmp_reg(8'(ops.size()), 8'h01);
      cmp_op(ops.pop_front() | 30'h3fff, {1'b1, r, 5'h00, 14'h3fff});
      rd(3'h4);
      cmp_reg(v, 8'h04);
      wr(3'h4, 8'h24);
      wr(3'h5, 8'h55);
      wr(3'h0, 8'h5a);
      wr(3'h4, 8'h26);
      rd(3'h4);
      cmp_reg(v & 8'h0a, 8'h08);
      wr(3'h4, 8'h20);
      unlock(8'h20);
      rd(3'h4);
      cmp_reg(v, 8'h20);
      cmp_reg(8'(ops.size()), 8'h00);
      // Region select set, armed start ignored
      wr(3'h4, 8'h44);
      unlock(8'h44);
      rd(3'h4);
      cmp_reg(v, 8'h44);
      cmp_reg(8'(ops.size()), 8'h00);
      prog(r, 0);
      load(10'h00f, 5'h00, 8'h04, 1'b0);
      rd(3'h4);
      cmp_reg(v, 8'h0c);
      cmp_reg(8'(ops.size()), 8'h00);
      rd(3'h6);
      cmp_reg(v & 8'h02, 8'h02);
      final_report();
   end
endmodule

bind flash_row_latch_writer flash_row_monitor u_flash_row_monitor (.clk_sys,
   .resetn, .flash_req, .flash_erase, .flash_row, .flash_word, .flash_wdata,
   .flash_ack, .protect_rows_below, .cpu_hold);

`default_nettype wire
